// ===== inc/accel_fe_pkg.sv
// shared constants, register map and state types of the acceleration decimation front end
package accel_fe_pkg;
    // clock and modulator bit timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int MOD_BIT_PERIOD_NS = 1000;
    localparam int MOD_DIV_CYCLES = MOD_BIT_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [4:0] MOD_DIV_LAST = 5'(MOD_DIV_CYCLES - 1);
    localparam logic [4:0] MOD_DIV_RESET = 5'h00;

    // sinc filter shape
    localparam int SINC_ORDER = 3;
    localparam int DECIM_FACTOR = 16;
    localparam logic [3:0] DECIM_LAST = 4'(DECIM_FACTOR - 1);
    localparam int WORD_W = 20;
    typedef logic signed [WORD_W-1:0] sample_t;
    localparam sample_t SAMPLE_ONE = 20'sh00001;
    localparam sample_t SINC_FULL_SCALE = 20'sh01000;

    // register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_DEFLECT = 8'h08;
    localparam logic [7:0] ADDR_SAMPLE = 8'h0c;

    // field positions
    localparam int CTRL_SELFTEST_BIT = 0;
    localparam int CTRL_PERIODIC_BIT = 1;
    localparam int CTRL_LOWRANGE_BIT = 2;
    localparam int STAT_ST_ACTIVE_BIT = 0;
    localparam int STAT_OVERRUN_BIT = 1;
    localparam int STAT_OUT_VALID_BIT = 2;

    // factory deflection code, 0x00 and 0xff are the two range ends
    localparam logic [7:0] DEFLECT_CODE_MIN = 8'h00;
    localparam logic [7:0] DEFLECT_CODE_MAX = 8'hff;
    localparam logic [7:0] DEFLECT_CODE_DEFAULT = 8'h80;

    typedef struct packed {
        logic low_range;
        logic periodic_collect_enable;
        logic selftest_request;
    } ctrl_t;
    localparam ctrl_t CTRL_RESET = 3'h0;

    typedef struct packed {
        logic valid;
        sample_t data;
    } sinc_out_t;

    typedef struct packed {
        logic [4:0] div_cnt;
        logic tick;
        logic mod_bit;
        ctrl_t ctrl;
        logic selftest_drive;
        logic overrun;
        logic push_valid;
        sample_t gained;
        sample_t last_sample;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } fe_state_t;
endpackage

// ===== src/sinc3_decimator.sv
// third order sinc decimator, one parallel word per sixteen modulator bits
`timescale 1ns/1ps
module sinc3_decimator (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic bit_en_i,
    input wire logic bit_i,
    output accel_fe_pkg::sinc_out_t out_o
);
    import accel_fe_pkg::*;

    typedef struct packed {
        sample_t i1;
        sample_t i2;
        sample_t i3;
        sample_t d1;
        sample_t d2;
        sample_t d3;
        logic [3:0] cnt;
        sinc_out_t out;
    } sinc_state_t;

    sinc_state_t s;
    sinc_state_t next_s;
    sample_t x;
    sample_t c1;
    sample_t c2;
    sample_t c3;

    // integrators at bit rate, combs at word rate; wraparound is harmless in a sinc
    always_comb begin
        next_s = s;
        next_s.out.valid = 1'b0;
        x = bit_i ? SAMPLE_ONE : -SAMPLE_ONE; // bit as +1 / -1
        c1 = s.i3 - s.d1;
        c2 = c1 - s.d2;
        c3 = c2 - s.d3;
        if (bit_en_i) begin
            next_s.i1 = s.i1 + x;
            next_s.i2 = s.i2 + s.i1;
            next_s.i3 = s.i3 + s.i2;
            next_s.cnt = s.cnt + 4'h1;
            if (s.cnt == DECIM_LAST) begin
                // dc gain 16^3 = 4096 equals 1.0 with 12 fraction bits
                next_s.d1 = s.i3;
                next_s.d2 = c1;
                next_s.d3 = c2;
                next_s.out.data = c3;
                next_s.out.valid = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign out_o = s.out;

    chk_sinc_bound: assert property (@(posedge clk_i) disable iff (rst_i)
        s.out.valid |-> (s.out.data <= SINC_FULL_SCALE && s.out.data >= -SINC_FULL_SCALE))
        else $error("sinc word beyond unity full scale");
endmodule

// ===== src/stream_skid_buffer.sv
// two-entry valid/ready buffer, output taken straight from the head register
`timescale 1ns/1ps
module stream_skid_buffer #(
    parameter int W = 20
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    input wire logic [W-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [W-1:0] out_data_o,
    input wire logic out_ready_i
);
    typedef struct packed {
        logic [W-1:0] head;
        logic [W-1:0] spare;
        logic head_valid;
        logic spare_valid;
    } buf_state_t;

    buf_state_t s;
    buf_state_t next_s;
    logic push;
    logic pop;

    // pop first, then place the pushed word in head or spare
    always_comb begin
        next_s = s;
        push = in_valid_i & ~s.spare_valid;
        pop = s.head_valid & out_ready_i;
        if (pop) begin
            if (s.spare_valid) begin
                next_s.head = s.spare;
                next_s.spare_valid = 1'b0;
            end else begin
                next_s.head_valid = 1'b0;
            end
        end
        if (push) begin
            if (!s.head_valid || (pop && !s.spare_valid)) begin
                next_s.head = in_data_i;
                next_s.head_valid = 1'b1;
            end else begin
                next_s.spare = in_data_i;
                next_s.spare_valid = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign in_ready_o = ~s.spare_valid;
    assign out_valid_o = s.head_valid;
    assign out_data_o = s.head;

    chk_head_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        s.head_valid && !out_ready_i |=> s.head_valid && $stable(s.head))
        else $error("stalled head word changed");
endmodule

// ===== src/accel_decimation_front_end.sv
// acceleration front end: modulator bit pacing, sinc decimation, gain, self-test gate, apb regs
//
// Summary of operation
// - modulator bitstream enters the signal processor
// - third order sinc, decimate by sixteen
// - sinc output words feed all later stages
// - each sinc word multiplied by one or two
// - gain follows the configured output range
// - self-test drives the proof mass deflection
// - self-test blocked while periodic collection enabled
// - factory deflection held as eight-bit code
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module accel_decimation_front_end #(
    parameter logic [7:0] FACTORY_DEFLECTION = accel_fe_pkg::DEFLECT_CODE_DEFAULT
) (
    input wire logic MCLK_I,
    input wire logic RST_I,
    input wire logic SIGMA_DELTA_STREAM_I,
    output logic MOD_TICK_O,
    output logic SELFTEST_DRIVE_O,
    output logic SAMPLE_STROBE_O,
    output accel_fe_pkg::sample_t SAMPLE_DATA_O,
    output logic SAMPLE_VALID_O,
    input wire logic SAMPLE_READY_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O
);
    import accel_fe_pkg::*;

    fe_state_t s;
    fe_state_t next_s;
    sinc_out_t sinc_out;
    logic buf_in_ready;
    logic access;
    logic finish;
    logic mapped;
    logic [31:0] rd_word;
    logic overrun_clr;
    logic overrun_set;

    // decimation core: one bit per tick, one word per sixteen ticks
    sinc3_decimator u_sinc (
        .clk_i(MCLK_I),
        .rst_i(RST_I),
        .bit_en_i(s.tick),
        .bit_i(s.mod_bit),
        .out_o(sinc_out)
    );

    // two words of slack so a short receiver stall loses nothing
    stream_skid_buffer #(
        .W(WORD_W)
    ) u_buf (
        .clk_i(MCLK_I),
        .rst_i(RST_I),
        .in_valid_i(s.push_valid),
        .in_data_i(s.gained),
        .in_ready_o(buf_in_ready),
        .out_valid_o(SAMPLE_VALID_O),
        .out_data_o(SAMPLE_DATA_O),
        .out_ready_i(SAMPLE_READY_I)
    );

    // register read mux and address decode
    always_comb begin
        rd_word = 32'h0000_0000;
        mapped = 1'b1;
        case (PADDR_I)
            ADDR_CTRL: begin
                rd_word[CTRL_SELFTEST_BIT] = s.ctrl.selftest_request;
                rd_word[CTRL_PERIODIC_BIT] = s.ctrl.periodic_collect_enable;
                rd_word[CTRL_LOWRANGE_BIT] = s.ctrl.low_range;
            end
            ADDR_STATUS: begin
                rd_word[STAT_ST_ACTIVE_BIT] = s.selftest_drive;
                rd_word[STAT_OVERRUN_BIT] = s.overrun;
                rd_word[STAT_OUT_VALID_BIT] = SAMPLE_VALID_O;
            end
            ADDR_DEFLECT: begin
                rd_word[7:0] = FACTORY_DEFLECTION;
            end
            ADDR_SAMPLE: begin
                rd_word = {{(32 - WORD_W){s.last_sample[WORD_W-1]}}, s.last_sample};
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // next state of the whole block
    always_comb begin
        next_s = s;
        access = PSEL_I & PENABLE_I;
        finish = access & s.pready;
        overrun_clr = 1'b0;
        overrun_set = 1'b0;

        // bit pacing: 25 clocks per modulator bit at 25 MHz
        next_s.tick = 1'b0;
        if (s.div_cnt == MOD_DIV_LAST) begin
            next_s.div_cnt = MOD_DIV_RESET;
            next_s.tick = 1'b1;
            next_s.mod_bit = SIGMA_DELTA_STREAM_I;
        end else begin
            next_s.div_cnt = s.div_cnt + 5'h01;
        end

        // gain stage; range bit picks one or two
        next_s.push_valid = 1'b0;
        if (sinc_out.valid) begin
            if (s.ctrl.low_range) begin
                next_s.gained = sinc_out.data <<< 1;
            end else begin
                next_s.gained = sinc_out.data;
            end
            next_s.push_valid = 1'b1;
        end
        if (s.push_valid) begin
            next_s.last_sample = s.gained;
            // buffer full: the word is dropped and flagged, the sensor cannot wait
            overrun_set = ~buf_in_ready;
        end

        // apb: one wait state, write takes effect at the completing edge
        next_s.pready = access & ~s.pready;
        next_s.pslverr = 1'b0;
        if (access && !s.pready) begin
            next_s.prdata = rd_word;
            next_s.pslverr = ~mapped;
        end
        if (finish && PWRITE_I) begin
            case (PADDR_I)
                ADDR_CTRL: begin
                    next_s.ctrl.periodic_collect_enable = PWDATA_I[CTRL_PERIODIC_BIT];
                    next_s.ctrl.low_range = PWDATA_I[CTRL_LOWRANGE_BIT];
                    // a request made with collection on has no effect
                    next_s.ctrl.selftest_request = PWDATA_I[CTRL_SELFTEST_BIT]
                        & ~PWDATA_I[CTRL_PERIODIC_BIT];
                end
                ADDR_STATUS: begin
                    overrun_clr = PWDATA_I[STAT_OVERRUN_BIT];
                end
                default: begin
                end
            endcase
        end
        // set wins over a clear in the same cycle
        next_s.overrun = (s.overrun & ~overrun_clr) | overrun_set;

        // deflection voltage only while collection is off
        next_s.selftest_drive = s.ctrl.selftest_request & ~s.ctrl.periodic_collect_enable;
    end

    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            s <= '0;
            s.ctrl <= CTRL_RESET;
            s.div_cnt <= MOD_DIV_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign MOD_TICK_O = s.tick;
    assign SELFTEST_DRIVE_O = s.selftest_drive;
    assign SAMPLE_STROBE_O = s.push_valid;
    assign PRDATA_O = s.prdata;
    assign PREADY_O = s.pready;
    assign PSLVERR_O = s.pslverr;

    // helper: ticks seen since the last sinc word
    logic [4:0] ticks_seen;
    always_ff @(posedge MCLK_I) begin
        if (RST_I || sinc_out.valid) begin
            ticks_seen <= 5'h00;
        end else if (s.tick) begin
            ticks_seen <= ticks_seen + 5'h01;
        end
    end

    sequence quiet8_s;
        (!s.tick) [*8];
    endsequence

    chk_tick_period: assert property (@(posedge MCLK_I) disable iff (RST_I)
        s.tick |=> quiet8_s ##17 s.tick)
        else $error("modulator tick spacing is not 25 clocks");

    chk_sinc_rate: assert property (@(posedge MCLK_I) disable iff (RST_I)
        sinc_out.valid |-> ticks_seen == 5'h10)
        else $error("sinc word not after sixteen bits");

    chk_gain_one: assert property (@(posedge MCLK_I) disable iff (RST_I)
        sinc_out.valid && !s.ctrl.low_range |=> s.push_valid && s.gained == $past(sinc_out.data))
        else $error("unity gain word differs from sinc word");

    chk_gain_two: assert property (@(posedge MCLK_I) disable iff (RST_I)
        sinc_out.valid && s.ctrl.low_range |=> s.gained == ($past(sinc_out.data) <<< 1))
        else $error("low range word is not doubled");

    chk_selftest_on: assert property (@(posedge MCLK_I) disable iff (RST_I)
        s.ctrl.selftest_request && !s.ctrl.periodic_collect_enable |=> SELFTEST_DRIVE_O)
        else $error("self-test requested but not driven");

    chk_selftest_block: assert property (@(posedge MCLK_I) disable iff (RST_I)
        s.ctrl.periodic_collect_enable |=> !SELFTEST_DRIVE_O)
        else $error("self-test driven during periodic collection");

    chk_deflect_read: assert property (@(posedge MCLK_I) disable iff (RST_I)
        PREADY_O && !PWRITE_I && PADDR_I == ADDR_DEFLECT |-> PRDATA_O == {24'h0, FACTORY_DEFLECTION})
        else $error("deflection code read wrong");

    chk_strobe_single: assert property (@(posedge MCLK_I) disable iff (RST_I)
        SAMPLE_STROBE_O |=> (!SAMPLE_STROBE_O) [*8])
        else $error("sample strobe longer than one cycle");

    chk_apb_wait: assert property (@(posedge MCLK_I) disable iff (RST_I)
        PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O)
        else $error("apb access not answered after one wait state");

    // helper: clocks since the previous gained word; the first word has no predecessor
    logic [8:0] since_strobe;
    logic strobe_seen;
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            since_strobe <= 9'h000;
            strobe_seen <= 1'b0;
        end else if (s.push_valid) begin
            since_strobe <= 9'h001;
            strobe_seen <= 1'b1;
        end else if (since_strobe != 9'h1ff) begin
            since_strobe <= since_strobe + 9'h001;
        end
    end

    chk_word_spacing: assert property (@(posedge MCLK_I) disable iff (RST_I)
        SAMPLE_STROBE_O && strobe_seen |-> since_strobe == 9'h190)
        else $error("gained words not 400 clocks apart");

    chk_tick_single: assert property (@(posedge MCLK_I) disable iff (RST_I)
        s.tick |=> !s.tick)
        else $error("modulator tick longer than one cycle");

    chk_tick_phase: assert property (@(posedge MCLK_I) disable iff (RST_I)
        s.tick |-> s.div_cnt == MOD_DIV_RESET)
        else $error("modulator tick off the divider wrap");

    chk_bit_capture: assert property (@(posedge MCLK_I) disable iff (RST_I)
        s.div_cnt == MOD_DIV_LAST |=> s.tick && s.mod_bit == $past(SIGMA_DELTA_STREAM_I))
        else $error("modulator bit not captured at the divider wrap");

    chk_bit_hold: assert property (@(posedge MCLK_I) disable iff (RST_I)
        s.div_cnt != MOD_DIV_LAST |=> $stable(s.mod_bit))
        else $error("modulator bit changed between ticks");

    chk_sinc_single: assert property (@(posedge MCLK_I) disable iff (RST_I)
        sinc_out.valid |=> !sinc_out.valid)
        else $error("sinc valid longer than one cycle");

    chk_sinc_after_tick: assert property (@(posedge MCLK_I) disable iff (RST_I)
        sinc_out.valid |-> $past(s.tick))
        else $error("sinc word not launched by a tick");

    chk_ticks_bounded: assert property (@(posedge MCLK_I) disable iff (RST_I)
        ticks_seen <= 5'h10)
        else $error("more than sixteen bits without a sinc word");

    chk_strobe_follows: assert property (@(posedge MCLK_I) disable iff (RST_I)
        sinc_out.valid |=> SAMPLE_STROBE_O)
        else $error("sinc word not passed to the gain stage");

    chk_strobe_source: assert property (@(posedge MCLK_I) disable iff (RST_I)
        SAMPLE_STROBE_O |-> $past(sinc_out.valid))
        else $error("sample strobe without a sinc word");

    chk_last_sample: assert property (@(posedge MCLK_I) disable iff (RST_I)
        SAMPLE_STROBE_O |=> s.last_sample == $past(s.gained))
        else $error("last sample register not updated");

    chk_buffer_accept: assert property (@(posedge MCLK_I) disable iff (RST_I)
        SAMPLE_STROBE_O && buf_in_ready |=> SAMPLE_VALID_O)
        else $error("accepted word not offered downstream");

    chk_overrun_set: assert property (@(posedge MCLK_I) disable iff (RST_I)
        SAMPLE_STROBE_O && !buf_in_ready |=> s.overrun)
        else $error("dropped word not flagged");

    chk_out_hold: assert property (@(posedge MCLK_I) disable iff (RST_I)
        SAMPLE_VALID_O && !SAMPLE_READY_I |=> SAMPLE_VALID_O && $stable(SAMPLE_DATA_O))
        else $error("stalled output word changed");

    chk_unity_bound: assert property (@(posedge MCLK_I) disable iff (RST_I)
        SAMPLE_STROBE_O && !$past(s.ctrl.low_range) |-> s.gained <= SINC_FULL_SCALE
            && s.gained >= -SINC_FULL_SCALE)
        else $error("unity gain word beyond full scale");

    chk_double_even: assert property (@(posedge MCLK_I) disable iff (RST_I)
        SAMPLE_STROBE_O && $past(s.ctrl.low_range) |-> !s.gained[0])
        else $error("doubled word is odd");

    chk_st_refused: assert property (@(posedge MCLK_I) disable iff (RST_I)
        finish && PWRITE_I && PADDR_I == ADDR_CTRL && PWDATA_I[CTRL_PERIODIC_BIT]
            |=> !s.ctrl.selftest_request)
        else $error("self-test request kept with collection on");

    chk_st_accepted: assert property (@(posedge MCLK_I) disable iff (RST_I)
        finish && PWRITE_I && PADDR_I == ADDR_CTRL && PWDATA_I[CTRL_SELFTEST_BIT]
            && !PWDATA_I[CTRL_PERIODIC_BIT] |=> s.ctrl.selftest_request)
        else $error("self-test request lost with collection off");

    chk_drive_source: assert property (@(posedge MCLK_I) disable iff (RST_I)
        SELFTEST_DRIVE_O |-> $past(s.ctrl.selftest_request)
            && !$past(s.ctrl.periodic_collect_enable))
        else $error("deflection drive without a valid request");

    chk_drive_release: assert property (@(posedge MCLK_I) disable iff (RST_I)
        !s.ctrl.selftest_request |=> !SELFTEST_DRIVE_O)
        else $error("deflection drive left on after request cleared");

    chk_err_with_ready: assert property (@(posedge MCLK_I) disable iff (RST_I)
        PSLVERR_O |-> PREADY_O)
        else $error("apb error without ready");

    chk_ready_single: assert property (@(posedge MCLK_I) disable iff (RST_I)
        PREADY_O |=> !PREADY_O)
        else $error("apb ready longer than one cycle");

    chk_ready_cause: assert property (@(posedge MCLK_I) disable iff (RST_I)
        PREADY_O |-> $past(PSEL_I) && $past(PENABLE_I))
        else $error("apb ready without an access phase");

    chk_prdata_stands: assert property (@(posedge MCLK_I) disable iff (RST_I)
        !(PSEL_I && PENABLE_I && !PREADY_O) |=> $stable(PRDATA_O))
        else $error("read data changed outside an access");

    chk_status_read: assert property (@(posedge MCLK_I) disable iff (RST_I)
        PREADY_O && !PWRITE_I && PADDR_I == ADDR_STATUS
            |-> PRDATA_O[STAT_OVERRUN_BIT] == $past(s.overrun))
        else $error("status read shows a wrong overrun flag");

    chk_sample_read: assert property (@(posedge MCLK_I) disable iff (RST_I)
        PREADY_O && !PWRITE_I && PADDR_I == ADDR_SAMPLE
            |-> PRDATA_O[WORD_W-1:0] == $past(s.last_sample))
        else $error("sample register read wrong");
endmodule

// ===== test/sd_modulator_model.sv
// behavioural sigma-delta modulator standing in for the sensing element
`timescale 1ns/1ps
module sd_modulator_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic [1:0] mode_i,
    output logic bit_o
);
    // next bit launched just after the tick, settled long before the next capture
    // mode 0 all low (-1), mode 1 all high (+1), otherwise alternating
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bit_o <= 1'b0;
        end else if (tick_i) begin
            case (mode_i)
                2'h0: bit_o <= 1'b0;
                2'h1: bit_o <= 1'b1;
                default: bit_o <= ~bit_o;
            endcase
        end
    end
endmodule

// ===== test/accel_decimation_front_end_tb.sv
// self-checking bench: apb register access, decimated stream, gain and self-test gate
`timescale 1ns/1ps
module accel_decimation_front_end_tb;
    import accel_fe_pkg::*;
    localparam logic [7:0] FACT = 8'h3c; // arbitrary production code
    localparam int DST_MIN = 45; // arbitrary minimum deflection, in code steps
    localparam int DST_ACC_PCT = 10; // arbitrary deflection accuracy, percent
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic ready = 1'b1;
    logic [1:0] mode = 2'h1;
    logic sd_bit, tick, drive, strobe, out_valid, pready, pslverr, err;
    sample_t out_data, w;
    logic [31:0] prdata, rd;
    int err_count = 0;
    int check_count = 0;
    int n, t, lim_lo, lim_hi;
    // stimulus table: stream pattern, range select, expected settled word
    logic [1:0] tmode [5] = '{2'h1, 2'h0, 2'h1, 2'h0, 2'h2};
    logic tgain [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    sample_t texp [5] = '{20'sh01000, -20'sh01000, 20'sh02000, -20'sh02000, 20'sh00000};

    accel_decimation_front_end #(.FACTORY_DEFLECTION(FACT)) accel_decimation_front_end_inst (
        .MCLK_I(clk), .RST_I(rst), .SIGMA_DELTA_STREAM_I(sd_bit), .MOD_TICK_O(tick),
        .SELFTEST_DRIVE_O(drive), .SAMPLE_STROBE_O(strobe), .SAMPLE_DATA_O(out_data),
        .SAMPLE_VALID_O(out_valid), .SAMPLE_READY_I(ready), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr));

    sd_modulator_model sd_modulator_model_inst (
        .clk_i(clk), .rst_i(rst), .tick_i(tick), .mode_i(mode), .bit_o(sd_bit));

    // 25 MHz clock
    initial begin
        forever #20 clk = ~clk;
    end

    task automatic final_report();
        if (err_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // a used-up bound counts as a mismatch and ends the run
    task automatic bound(input int cnt, input int lim);
        if (cnt >= lim) begin
            chk(32'(cnt), 32'(lim - 1));
            final_report();
        end
    endtask

    // one apb transfer, request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        bound(k, 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_strobes(input int cnt);
        int k;
        repeat (cnt) begin
            k = 0;
            do begin
                @(posedge clk);
                k++;
            end while (strobe !== 1'b1 && k < 1000);
            bound(k, 1000);
        end
    endtask

    // word taken at the edge where valid is seen with ready high
    task automatic get_word();
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (out_valid !== 1'b1 && k < 1000);
        bound(k, 1000);
        w = out_data;
    endtask

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        // reset values, read-only code, unmapped address
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, ADDR_DEFLECT, 32'h55);
        apb(1'b0, ADDR_DEFLECT, 32'h0);
        chk(rd, {24'h0, FACT});
        // host side delta limits from the stored code: floor below, ceiling above
        lim_lo = ((DST_MIN + int'(rd[7:0])) * (100 - DST_ACC_PCT)) / 100;
        lim_hi = ((DST_MIN + int'(rd[7:0])) * (100 + DST_ACC_PCT) + 99) / 100;
        chk(32'(lim_lo), 32'h0000_005e);
        chk(32'(lim_hi), 32'h0000_0074);
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, err}, 32'h1);
        // modulator pacing and decimation ratio
        wait_strobes(1);
        n = 0;
        t = 0;
        do begin
            @(posedge clk);
            n++;
            t += int'(tick === 1'b1);
        end while (strobe !== 1'b1 && n < 1000);
        chk(32'(n), 32'd400);
        chk(32'(t), 32'd16);
        // settled words for each pattern and gain, both on the stream and in the register
        for (int i = 0; i < 5; i++) begin
            mode <= tmode[i];
            apb(1'b1, ADDR_CTRL, {29'h0, tgain[i], 2'b00});
            wait_strobes(5);
            get_word();
            chk(32'(w), 32'(texp[i]));
            apb(1'b0, ADDR_SAMPLE, 32'h0);
            chk(rd, 32'(texp[i]));
        end
        // receiver stalls: two words kept, third dropped and flagged
        ready <= 1'b0;
        wait_strobes(3);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h6);
        chk(32'(out_data), 32'h0);
        ready <= 1'b1;
        get_word();
        chk(32'(w), 32'h0);
        get_word();
        chk(32'(w), 32'h0);
        @(posedge clk);
        chk({31'h0, out_valid}, 32'h0);
        apb(1'b1, ADDR_STATUS, 32'h2);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h0);
        // self-test gate against periodic collection
        apb(1'b1, ADDR_CTRL, 32'h1);
        repeat (3) @(posedge clk);
        chk({31'h0, drive}, 32'h1);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd & 32'h1, 32'h1);
        apb(1'b1, ADDR_CTRL, 32'h3);
        repeat (3) @(posedge clk);
        chk({31'h0, drive}, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h3);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(rd, 32'h2);
        chk({31'h0, drive}, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h1);
        repeat (3) @(posedge clk);
        chk({31'h0, drive}, 32'h1);
        apb(1'b1, ADDR_CTRL, 32'h0);
        repeat (3) @(posedge clk);
        chk({31'h0, drive}, 32'h0);
        final_report();
    end
endmodule
